// ===== can_mode_consts.svh
// Offsets, field positions, reset values and timing figures
// Assumes a single 40 MHz clock and a byte-addressed AHB-Lite slave with 32-bit registers
`ifndef CAN_MODE_CONSTS_SVH
`define CAN_MODE_CONSTS_SVH

`define CLK_PERIOD_NS 25
`define FILTER_TIME_NS 1000
`define TXD_TIMEOUT_NS 1000000
`define WAKE_REACTION_NS 2000
`define MODE_CHANGE_NS 20000

`define REG_CTRL_ADDR 8'h00
`define REG_STATUS_ADDR 8'h04
`define CTRL_TIMEOUT_EN_BIT 0
`define CTRL_OVERTEMP_EN_BIT 1
`define CTRL_RESET 32'h0000_0003
`define STAT_MODE_LSB 0
`define STAT_CHANGING_BIT 2
`define STAT_TIMEOUT_BIT 3
`define STAT_OVERTEMP_BIT 4
`define STAT_WAKE_BIT 5

`endif

// ===== can_mode_pkg.sv
// Types shared by the transceiver mode controller
// Assumes the constants header is included by the design file
package can_mode_pkg;

   typedef enum logic [1:0] {
      MODE_POWER_DOWN,
      MODE_STANDBY,
      MODE_FORCED_STANDBY,
      MODE_NORMAL
   } mode_type;

   typedef struct packed {
      logic txd;
      logic mode_select_input;
      logic logic_supply_good;
      logic tx_supply_good;
      logic overtemp;
      logic bus_dominant;
   } pins_type;

   typedef struct packed {
      logic bus_drive_dominant;
      logic bias_mid_on;
      logic bias_gnd_on;
      logic normal_rx_on;
      logic low_power_rx_on;
   } analog_ctrl_type;

endpackage

// ===== can_mode_ctrl.sv
// Mode, wake-up and fail-safe control of a high-speed CAN transceiver
// Assumes all pin-side inputs are asynchronous and an AHB-Lite master
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "can_mode_consts.svh"

module can_mode_ctrl
   import can_mode_pkg::*;
#(
   parameter int TXD_TIMEOUT_CYC = `TXD_TIMEOUT_NS / `CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire pins_type pins,
   output logic rxd,
   output analog_ctrl_type analog,
   output mode_type mode
);

   localparam int FILTER_CYC =
      (`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int WAKE_CYC = `WAKE_REACTION_NS / `CLK_PERIOD_NS;
   localparam int MODE_CYC = `MODE_CHANGE_NS / `CLK_PERIOD_NS;
   localparam int MODE_BOUND = MODE_CYC + 2;
   localparam int WAKE_BOUND = WAKE_CYC;

   logic rst_meta_r, rst_n;
   pins_type sync1_r, sync2_r;
   mode_type mode_r, tgt_r, tgt_nxt;
   logic changing_r;
   logic [11:0] mode_cnt_r;
   logic [11:0] filt_cnt_r;
   logic filt_r, armed_r;
   logic [15:0] to_cnt_r;
   logic to_block_r, txd_prev_r;
   logic [31:0] ctrl_r;
   logic addr_ok_r, wr_pend_r;
   logic [7:0] addr_r;
   logic rxd_r;
   analog_ctrl_type analog_r;
   logic low_power, normal_run, tx_allowed, ot_block;

   // Reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // Pin and analog conditions, two-flop synchronised
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end

   // Requested mode from supplies and mode-select
   always_comb begin
      tgt_nxt = mode_r;
      if (!sync2_r.logic_supply_good) begin
         tgt_nxt = MODE_POWER_DOWN;
      end else begin
         case (mode_r)
            MODE_POWER_DOWN: begin
               if (sync2_r.mode_select_input) begin
                  tgt_nxt = MODE_STANDBY;
               end else if (sync2_r.tx_supply_good) begin
                  tgt_nxt = MODE_NORMAL;
               end else begin
                  tgt_nxt = MODE_FORCED_STANDBY;
               end
            end
            MODE_STANDBY: begin
               // Supply loss ignored here so it may be switched off
               if (!sync2_r.mode_select_input && sync2_r.tx_supply_good) begin
                  tgt_nxt = MODE_NORMAL;
               end
            end
            MODE_FORCED_STANDBY: begin
               if (sync2_r.mode_select_input) begin
                  tgt_nxt = MODE_STANDBY;
               end else if (sync2_r.tx_supply_good) begin
                  tgt_nxt = MODE_NORMAL;
               end
            end
            MODE_NORMAL: begin
               if (sync2_r.mode_select_input) begin
                  tgt_nxt = MODE_STANDBY;
               end else if (!sync2_r.tx_supply_good) begin
                  tgt_nxt = MODE_FORCED_STANDBY;
               end
            end
            default: tgt_nxt = MODE_POWER_DOWN;
         endcase
      end
   end

   // Mode change sequencing; power-down takes effect at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= MODE_POWER_DOWN;
         tgt_r <= MODE_POWER_DOWN;
         changing_r <= 1'b0;
         mode_cnt_r <= '0;
      end else if (tgt_nxt == MODE_POWER_DOWN) begin
         mode_r <= MODE_POWER_DOWN;
         tgt_r <= MODE_POWER_DOWN;
         changing_r <= 1'b0;
         mode_cnt_r <= '0;
      end else if (!changing_r) begin
         if (tgt_nxt != mode_r) begin
            tgt_r <= tgt_nxt;
            changing_r <= 1'b1;
            mode_cnt_r <= '0;
         end
      end else if (mode_cnt_r == 12'(MODE_CYC - 1)) begin
         mode_r <= tgt_r;
         changing_r <= 1'b0;
      end else begin
         mode_cnt_r <= mode_cnt_r + 12'h001;
      end
   end

   assign low_power = !changing_r &&
      (mode_r == MODE_STANDBY || mode_r == MODE_FORCED_STANDBY);
   assign normal_run = !changing_r && mode_r == MODE_NORMAL;

   // Activity filter of the low-power receiver
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_r <= 1'b0;
         filt_cnt_r <= '0;
         armed_r <= 1'b0;
      end else if (!low_power) begin
         // Start from the bus level so a stuck dominant bus cannot wake
         filt_r <= sync2_r.bus_dominant;
         filt_cnt_r <= '0;
         armed_r <= 1'b0;
      end else if (sync2_r.bus_dominant == filt_r) begin
         filt_cnt_r <= '0;
      end else if (filt_cnt_r == 12'(FILTER_CYC - 1)) begin
         filt_r <= sync2_r.bus_dominant;
         filt_cnt_r <= '0;
         if (sync2_r.bus_dominant) begin
            armed_r <= 1'b1;
         end
      end else begin
         filt_cnt_r <= filt_cnt_r + 12'h001;
      end
   end

   // Dominant time-out on the transmit input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         to_cnt_r <= '0;
         to_block_r <= 1'b0;
         txd_prev_r <= 1'b1;
      end else begin
         txd_prev_r <= sync2_r.txd;
         if (sync2_r.txd) begin
            to_cnt_r <= '0;
            if (!txd_prev_r) begin
               to_block_r <= 1'b0;
            end
         end else if (normal_run && ctrl_r[`CTRL_TIMEOUT_EN_BIT]) begin
            if (to_cnt_r == 16'(TXD_TIMEOUT_CYC - 1)) begin
               to_block_r <= 1'b1;
            end else begin
               to_cnt_r <= to_cnt_r + 16'h0001;
            end
         end
      end
   end

   // Sensor carries its own hysteresis
   assign ot_block = normal_run && sync2_r.overtemp &&
      ctrl_r[`CTRL_OVERTEMP_EN_BIT];
   assign tx_allowed = normal_run && !to_block_r && !ot_block;

   // Registered pin-side controls and receive output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxd_r <= 1'b1;
         analog_r <= '0;
      end else begin
         analog_r.bus_drive_dominant <= tx_allowed && !sync2_r.txd;
         analog_r.bias_mid_on <= mode_r == MODE_NORMAL;
         analog_r.bias_gnd_on <= mode_r == MODE_STANDBY ||
            mode_r == MODE_FORCED_STANDBY;
         analog_r.normal_rx_on <= normal_run;
         analog_r.low_power_rx_on <= mode_r == MODE_STANDBY ||
            mode_r == MODE_FORCED_STANDBY;
         if (normal_run) begin
            rxd_r <= !sync2_r.bus_dominant;
         end else if (low_power && armed_r) begin
            rxd_r <= !filt_r;
         end else begin
            rxd_r <= 1'b1;
         end
      end
   end

   assign rxd = rxd_r;
   assign analog = analog_r;
   assign mode = mode_r;

   // AHB-Lite slave, zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= '0;
         addr_ok_r <= 1'b0;
         wr_pend_r <= 1'b0;
         hrdata <= '0;
      end else begin
         wr_pend_r <= 1'b0;
         if (hsel && hready && htrans[1]) begin
            addr_r <= haddr;
            addr_ok_r <= hsize == 3'h2;
            wr_pend_r <= hwrite;
            hrdata <= '0;
            if (!hwrite && haddr == `REG_CTRL_ADDR) begin
               hrdata <= ctrl_r;
            end else if (!hwrite && haddr == `REG_STATUS_ADDR) begin
               hrdata[`STAT_MODE_LSB +: 2] <= mode_r;
               hrdata[`STAT_CHANGING_BIT] <= changing_r;
               hrdata[`STAT_TIMEOUT_BIT] <= to_block_r;
               hrdata[`STAT_OVERTEMP_BIT] <= ot_block;
               hrdata[`STAT_WAKE_BIT] <= armed_r;
            end
         end
      end
   end

   // Only the two enable bits are writable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `CTRL_RESET;
      end else if (wr_pend_r && addr_ok_r && addr_r == `REG_CTRL_ADDR) begin
         ctrl_r <= {30'h0000_0000, hwdata[1:0]};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   pd_priority_a: assert property (
      !sync2_r.logic_supply_good |=> mode_r == MODE_POWER_DOWN)
      else $error("no power-down on logic supply loss");
   pd_float_a: assert property (
      mode_r == MODE_POWER_DOWN |=> !analog.bias_mid_on && !analog.bias_gnd_on)
      else $error("bus biased in power-down");
   forced_quiet_a: assert property (
      mode_r == MODE_FORCED_STANDBY |=>
      !analog.bus_drive_dominant && analog.bias_gnd_on &&
      analog.low_power_rx_on && !analog.normal_rx_on)
      else $error("forced stand-by not quiet");
   forced_entry_a: assert property (
      tgt_nxt == MODE_FORCED_STANDBY && mode_r != MODE_FORCED_STANDBY
      |-> !sync2_r.tx_supply_good)
      else $error("forced stand-by with supply present");
   no_auto_wake_a: assert property (
      sync2_r.logic_supply_good && sync2_r.mode_select_input &&
      mode_r == MODE_STANDBY && !changing_r |=> mode_r == MODE_STANDBY)
      else $error("mode left stand-by on its own");
   timeout_hold_a: assert property (
      to_block_r && !sync2_r.txd |=> to_block_r ##1 !analog.bus_drive_dominant)
      else $error("transmitter released without rising edge");
   overtemp_block_a: assert property (
      ot_block && sync2_r.logic_supply_good |=>
      !analog.bus_drive_dominant && mode_r == MODE_NORMAL)
      else $error("transmitter active in overtemperature");
   change_rxd_a: assert property (
      changing_r |=> rxd)
      else $error("receive output not high during mode change");
   change_time_a: assert property (
      $rose(changing_r) |-> ##[1:MODE_BOUND] !changing_r)
      else $error("mode change too slow");
   standby_high_a: assert property (
      low_power && !armed_r |=> rxd)
      else $error("receive output not forced high before wake");
   wake_react_a: assert property (
      $rose(armed_r) |-> ##[0:WAKE_BOUND] !rxd)
      else $error("wake-up not shown in time");
   rxd_normal_a: assert property (
      normal_run |=> rxd != $past(sync2_r.bus_dominant))
      else $error("receive output not following bus");
   drive_follow_a: assert property (
      tx_allowed |=> analog.bus_drive_dominant != $past(sync2_r.txd))
      else $error("transmitter not following transmit input");
   timeout_rx_a: assert property (
      to_block_r && normal_run |=> analog.normal_rx_on)
      else $error("receiver off during time-out");
   release_edge_a: assert property (
      $fell(to_block_r) |-> $past(sync2_r.txd) && !$past(txd_prev_r))
      else $error("time-out cleared without rising edge");
   standby_bias_a: assert property (
      mode_r == MODE_STANDBY |=> analog.bias_gnd_on &&
      analog.low_power_rx_on && !analog.bias_mid_on &&
      !analog.bus_drive_dominant)
      else $error("stand-by bias or receiver wrong");
   normal_bias_a: assert property (
      mode_r == MODE_NORMAL |=> analog.bias_mid_on && !analog.bias_gnd_on &&
      !analog.low_power_rx_on)
      else $error("normal bias or receiver wrong");
   pd_outputs_a: assert property (
      mode_r == MODE_POWER_DOWN |=> rxd && !analog.bus_drive_dominant &&
      !analog.normal_rx_on && !analog.low_power_rx_on)
      else $error("receivers or transmitter on in power-down");
   normal_entry_a: assert property (
      mode_r != MODE_NORMAL && !changing_r &&
      sync2_r.logic_supply_good && !sync2_r.mode_select_input &&
      sync2_r.tx_supply_good |=> changing_r && tgt_r == MODE_NORMAL)
      else $error("normal operation not started");
   forced_exit_a: assert property (
      mode_r == MODE_FORCED_STANDBY && !changing_r &&
      sync2_r.logic_supply_good && sync2_r.mode_select_input
      |=> changing_r && tgt_r == MODE_STANDBY)
      else $error("forced stand-by not left on select high");
   standby_entry_a: assert property (
      mode_r == MODE_NORMAL && !changing_r &&
      sync2_r.logic_supply_good && sync2_r.mode_select_input
      |=> changing_r && tgt_r == MODE_STANDBY)
      else $error("stand-by not started from normal");
   supply_loss_a: assert property (
      normal_run && sync2_r.logic_supply_good &&
      !sync2_r.mode_select_input && !sync2_r.tx_supply_good
      |=> changing_r && tgt_r == MODE_FORCED_STANDBY)
      else $error("forced stand-by not started on supply loss");
   glitch_ignore_a: assert property (
      low_power && filt_cnt_r != 12'(FILTER_CYC - 1) |=> $stable(filt_r))
      else $error("bus glitch passed the activity filter");

endmodule // can_mode_ctrl

// ===== can_host_model.sv
// Host controller and bus stand-in facing the transceiver pins
// Assumes the bench commands it just after a rising clock edge
`timescale 1ns/1ps
module can_host_model (
   input wire logic clk,
   input wire logic tx_cmd,
   input wire logic sel_cmd,
   input wire logic remote_dom,
   input wire logic drive_dom,
   output logic txd,
   output logic mode_select_input,
   output logic bus_dominant
);
   logic txd_r = 1'b1;
   logic sel_r = 1'b1;
   // Host answers one cycle late, like firmware behind a port register
   always @(posedge clk) begin
      txd_r <= tx_cmd;
      sel_r <= sel_cmd;
   end
   assign txd = txd_r;
   assign mode_select_input = sel_r;
   // Wired bus: any driver makes it dominant
   assign bus_dominant = drive_dom | remote_dom;
endmodule // can_host_model

// ===== tb_top.sv
// Self-checking bench for the transceiver mode controller
// Assumes the host model on the pins and a zero-wait AHB-Lite slave
`timescale 1ns/1ps
module tb_top;
   import can_mode_pkg::*;
   logic clk, nrst, hsel, hwrite, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic lsup, tsup, hot, tx_cmd, sel_cmd, remote_dom, b;
   logic txd_p, sel_p, bus_p, rxd;
   pins_type pins;
   analog_ctrl_type analog;
   mode_type mode;
   int num_errors, checks_done;
   assign pins = {txd_p, sel_p, lsup, tsup, hot, bus_p};
   can_mode_ctrl #(.TXD_TIMEOUT_CYC(50)) i_dut (.clk(clk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
      .rxd(rxd), .analog(analog), .mode(mode));
   can_host_model i_host (.clk(clk), .tx_cmd(tx_cmd), .sel_cmd(sel_cmd),
      .remote_dom(remote_dom), .drive_dom(analog.bus_drive_dominant),
      .txd(txd_p), .mode_select_input(sel_p), .bus_dominant(bus_p));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task check(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task settle(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Single word transfer; read data lands in rd
   task ahb(logic w, logic [7:0] a, logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
      check("hresp", 32'(hresp), 32'h0);
   endtask
   // Receive output must stay high for the whole change
   task wait_mode(mode_type m, int lim);
      for (int i = 0; i < lim && mode !== m; i++) begin
         check("rxd held", 32'(rxd), 32'h1);
         settle(1);
      end
      check("mode", 32'(mode), 32'(m));
   endtask
   task wait_rxd(logic v, int lim);
      for (int i = 0; i < lim && rxd !== v; i++) settle(1);
      check("rxd", 32'(rxd), 32'(v));
   endtask
   function automatic analog_ctrl_type exp_analog(mode_type m, logic d);
      if (m == MODE_NORMAL) return {d, 4'hA};
      if (m == MODE_POWER_DOWN) return 5'h00;
      return 5'h05;
   endfunction
   initial begin
      repeat (15000) @(posedge clk);
      num_errors++;
      $display("unexpected watchdog expiry");
      results;
   end
   initial begin
      void'($urandom(8));
      {nrst, hsel, hwrite, haddr, htrans, hwdata} = '0;
      hsize = 3'h2;
      {lsup, tsup, hot, tx_cmd, sel_cmd, remote_dom} = 6'h36;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      wait_mode(MODE_STANDBY, 820);
      settle(2);
      check("analog", 32'(analog), 32'(exp_analog(MODE_STANDBY, 0)));
      ahb(0, 8'h04, 0);
      check("status mode", 32'(rd[1:0]), 32'(MODE_STANDBY));
      ahb(1, 8'h08, 32'hFFFF_FFFF);
      ahb(0, 8'h08, 0);
      check("unmapped", rd, 32'h0);
      ahb(0, 8'h00, 0);
      check("ctrl", rd, 32'h3);
      // Short bus pulses must not wake
      repeat (4) begin
         @(posedge clk) remote_dom <= 1'b1;
         settle(5 + $urandom % 30);
         @(posedge clk) remote_dom <= 1'b0;
         settle(50);
         check("rxd glitch", 32'(rxd), 32'h1);
      end
      @(posedge clk) remote_dom <= 1'b1;
      wait_rxd(1'b0, 125);
      check("mode wake", 32'(mode), 32'(MODE_STANDBY));
      @(posedge clk) remote_dom <= 1'b0;
      wait_rxd(1'b1, 125);
      @(posedge clk) tsup <= 1'b0;
      settle(850);
      check("mode no vcc", 32'(mode), 32'(MODE_STANDBY));
      @(posedge clk) tsup <= 1'b1;
      @(posedge clk) sel_cmd <= 1'b0;
      wait_mode(MODE_NORMAL, 820);
      repeat (20) begin
         b = 1'($urandom % 2);
         @(posedge clk) tx_cmd <= b;
         settle(8);
         check("drive", 32'(analog), 32'(exp_analog(MODE_NORMAL, !b)));
         check("rxd loop", 32'(rxd), 32'(b));
         @(posedge clk) tx_cmd <= 1'b1;
         settle(2);
      end
      // Overtemperature while sending dominant
      @(posedge clk) tx_cmd <= 1'b0;
      settle(8);
      @(posedge clk) hot <= 1'b1;
      settle(8);
      check("drive hot", 32'(analog.bus_drive_dominant), 32'h0);
      check("mode hot", 32'(mode), 32'(MODE_NORMAL));
      @(posedge clk) hot <= 1'b0;
      settle(8);
      check("drive cool", 32'(analog.bus_drive_dominant), 32'h1);
      // Stuck dominant input trips the time-out
      settle(70);
      check("drive stuck", 32'(analog.bus_drive_dominant), 32'h0);
      ahb(0, 8'h04, 0);
      check("status block", 32'(rd[3]), 32'h1);
      @(posedge clk) remote_dom <= 1'b1;
      settle(8);
      check("rxd stuck", 32'(rxd), 32'h0);
      @(posedge clk) remote_dom <= 1'b0;
      tx_cmd <= 1'b1;
      settle(4);
      @(posedge clk) tx_cmd <= 1'b0;
      settle(8);
      check("drive again", 32'(analog.bus_drive_dominant), 32'h1);
      @(posedge clk) tx_cmd <= 1'b1;
      // Own dominant must clear the receive path before the change
      settle(8);
      @(posedge clk) tsup <= 1'b0;
      wait_mode(MODE_FORCED_STANDBY, 820);
      settle(2);
      check("analog fsb", 32'(analog), 32'(exp_analog(MODE_STANDBY, 0)));
      @(posedge clk) remote_dom <= 1'b1;
      wait_rxd(1'b0, 125);
      @(posedge clk) remote_dom <= 1'b0;
      wait_rxd(1'b1, 125);
      @(posedge clk) sel_cmd <= 1'b1;
      wait_mode(MODE_STANDBY, 820);
      @(posedge clk) lsup <= 1'b0;
      wait_mode(MODE_POWER_DOWN, 4);
      settle(2);
      check("analog pd", 32'(analog), 32'h0);
      // Select low before the logic supply returns: straight to normal
      @(posedge clk) sel_cmd <= 1'b0;
      tsup <= 1'b1;
      settle(4);
      @(posedge clk) lsup <= 1'b1;
      wait_mode(MODE_NORMAL, 820);
      @(posedge clk) sel_cmd <= 1'b1;
      wait_mode(MODE_STANDBY, 820);
      settle(2);
      check("analog sb", 32'(analog), 32'(exp_analog(MODE_STANDBY, 0)));
      @(posedge clk) hot <= 1'b1;
      settle(4);
      ahb(0, 8'h04, 0);
      check("status sb hot", 32'(rd[4]), 32'h0);
      @(posedge clk) {lsup, tsup, hot, sel_cmd} <= 4'h0;
      wait_mode(MODE_POWER_DOWN, 4);
      settle(4);
      @(posedge clk) lsup <= 1'b1;
      wait_mode(MODE_FORCED_STANDBY, 820);
      // Reset again in mid-run: the mode comes back up the same way
      @(posedge clk) nrst <= 1'b0;
      settle(3);
      check("mode rst", 32'(mode), 32'(MODE_POWER_DOWN));
      @(posedge clk) nrst <= 1'b1;
      wait_mode(MODE_FORCED_STANDBY, 820);
      results;
   end
endmodule // tb_top
